//--- inc/pms_pkg.sv
// package: offsets, fields, timing and carrier types of the power mode sequencer
package pms_pkg;

  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam int         ADDR_W             = 8;
  localparam logic [7:0] REG_POWER_CONTROL  = 8'h00;
  localparam logic [7:0] REG_PERIPHERAL_CONFIG_REG_CONFIG  = 8'h04;
  localparam logic [7:0] REG_TIMER_CONTROL  = 8'h08;
  localparam logic [7:0] REG_IRQ_ONE_CONFIG = 8'h0C;
  localparam logic [7:0] REG_SWITCH_CONTROL = 8'h10;
  localparam logic [7:0] REG_STATUS         = 8'h14;
  localparam logic [7:0] REG_DISPLAY        = 8'h18;
  localparam logic [7:0] REG_RETAIN_BASE    = 8'h20;
  localparam int         RETAIN_WORDS       = 4;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PWR_SLEEP_BIT   = 4;
  localparam int PWR_SWRESET_BIT = 7;
  localparam int PER_RX_FLAG_BIT = 7;
  localparam int PER_SOURCE_BIT  = 6;
  localparam int TIMER_CONTROL_REG_PEND_BIT   = 3;
  localparam int TIMER_CONTROL_REG_EDGE_BIT   = 2;
  localparam int SW_BSO_IE_BIT   = 0;
  localparam int SW_PSR_IE_BIT   = 1;
  localparam int SW_AUTO_MAIN    = 2;
  localparam int SW_AUTO_DC      = 3;
  localparam int SW_DC_WARN      = 4;
  localparam int DISP_ON_BIT     = 0;

  localparam logic [1:0] RX_WAKE_CFG   = 2'h3;
  localparam logic [1:0] IRQ1_WAKE_CFG = 2'h3;

  // ****************************************************************
  // reset values and bus responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  localparam logic [4:0] SWITCH_RESET    = 5'h04;
  // pins order: main_ok, main_low, dc_low, irq_one, rx, reset_n
  localparam logic [5:0] PIN_SYNC_RESET  = 6'h23;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint CLOCK_HZ        = 125000000;
  localparam longint DC_SWITCH_MS    = 30;
  localparam int     DC_SWITCH_CYCLES =
    int'((DC_SWITCH_MS * CLOCK_HZ) / 1000);

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    PMS_FULL_SUPPLY,
    PMS_BATTERY_RUN,
    PMS_SLEEP
  } pms_mode_t;

  typedef struct packed {
    logic main_ok;
    logic main_low;
    logic dc_low;
  } pms_supply_t;

  typedef struct packed {
    logic supply_on_battery;
    logic core_run;
    logic core_restart;
    logic analog_enable;
    logic display_enable;
    logic early_warning;
    logic wake_event;
  } pms_power_t;

endpackage : pms_pkg

//--- verilog/pms_retain_mem.sv
// retained user bytes: small memory with registered read data
`timescale 1ns/1ps
module pms_retain_mem #(
  parameter int WORDS = 4,
  parameter int WIDTH = 8
) (
  input  wire logic                     i_clock,
  input  wire logic                     i_wr_en,
  input  wire logic [$clog2(WORDS)-1:0] i_wr_addr,
  input  wire logic [WIDTH-1:0]         i_wr_data,
  input  wire logic [$clog2(WORDS)-1:0] i_rd_addr,
  output logic      [WIDTH-1:0]         o_rd_data
);
  // no reset on purpose: contents must outlive sleep and core restarts
  logic [WIDTH-1:0] mem_reg [WORDS];

  initial begin
    if (WORDS < 2 || WIDTH < 1) begin
      $error("pms_retain_mem: unsupported geometry");
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_wr_en) begin
      mem_reg[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock) begin
    o_rd_data <= mem_reg[i_rd_addr];
  end
endmodule : pms_retain_mem

//--- verilog/pms_mode_ctrl.sv
// power mode sequencer: supply tracking, sleep and wake, AXI4-Lite regs
//
// Contract
// RULE1 - irq-one config 11x: selected edge on that pin wakes from sleep
// RULE2 - irq-one wake leaves the irq-one pending flag untouched
// RULE3 - software acknowledges pending irq-one before commanding sleep
// RULE4 - receive config 11: any receive edge wakes and sets receive flag
// RULE5 - software clears the receive flag before commanding sleep
// RULE6 - reset pin low in sleep wakes to battery run, never masked
// RULE7 - display switchable in sleep, display data kept through sleep
// RULE8 - four retained user bytes keep contents during sleep
// RULE9 - change of switched supply source changes operating mode
// RULE10 - switchover to battery: full mode to battery run, analog off
// RULE11 - on battery, writing sleep bit stops core and enters sleep
// RULE12 - wake from sleep into battery run restarts at reset vector
// RULE13 - main restored in sleep: full mode, core and analog restart
// RULE14 - main restored in battery run: analog restarts, code continues
// RULE15 - software may issue software reset after return to full mode
// RULE16 - source flag bit 6 of peripheral config shows supply source
// RULE17 - software enables switchover interrupt when powered on main
// RULE18 - software enables restore interrupt when powered on battery
// RULE19 - early warning from voltage dip and enabled low dc input
// RULE20 - software backs up data before enabling low dc switchover
// RULE21 - low dc switchover moves supply to battery 30 ms after enable
// RULE22 - main restore wakes unmaskably and sets source flag to main
// RULE23 - three distinct modes, full supply mode after power-on reset
`timescale 1ns/1ps
module pms_mode_ctrl #(
  parameter int DC_DELAY_CYCLES = pms_pkg::DC_SWITCH_CYCLES
) (
  input  wire logic                        i_clock,
  input  wire logic                        i_reset,
  input  wire logic                        i_awvalid,
  output logic                             o_awready,
  input  wire logic [pms_pkg::ADDR_W-1:0]  i_awaddr,
  input  wire logic                        i_wvalid,
  output logic                             o_wready,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic [3:0]                  i_wstrb,
  output logic                             o_bvalid,
  input  wire logic                        i_bready,
  output logic      [1:0]                  o_bresp,
  input  wire logic                        i_arvalid,
  output logic                             o_arready,
  input  wire logic [pms_pkg::ADDR_W-1:0]  i_araddr,
  output logic                             o_rvalid,
  input  wire logic                        i_rready,
  output logic      [31:0]                 o_rdata,
  output logic      [1:0]                  o_rresp,
  input  wire pms_pkg::pms_supply_t        i_supply,
  input  wire logic                        i_irq_one_pin,
  input  wire logic                        i_rx_pin,
  input  wire logic                        i_reset_pin_n,
  output pms_pkg::pms_mode_t               o_mode,
  output pms_pkg::pms_power_t              o_power
);

  initial begin
    if (DC_DELAY_CYCLES < 1) begin
      $error("pms_mode_ctrl: DC_DELAY_CYCLES must be at least 1");
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic is_retain(input logic [7:0] addr);
    return addr >= pms_pkg::REG_RETAIN_BASE &&
           addr < pms_pkg::REG_RETAIN_BASE + 8'(4 * pms_pkg::RETAIN_WORDS);
  endfunction : is_retain

  function automatic logic is_mapped(input logic [7:0] addr);
    return addr[1:0] == 2'h0 &&
           (addr <= pms_pkg::REG_DISPLAY || is_retain(addr));
  endfunction : is_mapped

  function automatic logic [1:0] retain_index(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - pms_pkg::REG_RETAIN_BASE;
    return off[3:2];
  endfunction : retain_index

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic       irq_one_prev_reg;
  logic       rx_prev_reg;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      sync1_reg <= pms_pkg::PIN_SYNC_RESET;
      sync2_reg <= pms_pkg::PIN_SYNC_RESET;
    end else begin
      sync1_reg <= {i_supply.main_ok, i_supply.main_low, i_supply.dc_low,
                    i_irq_one_pin, i_rx_pin, i_reset_pin_n};
      sync2_reg <= sync1_reg;
    end
  end

  logic main_ok;
  logic main_low;
  logic dc_low;
  logic irq_one_s;
  logic rx_s;
  logic reset_pin_n_s;
  assign {main_ok, main_low, dc_low, irq_one_s, rx_s, reset_pin_n_s} =
    sync2_reg;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      irq_one_prev_reg <= 1'b0;
      rx_prev_reg      <= 1'b1;
    end else begin
      irq_one_prev_reg <= irq_one_s;
      rx_prev_reg      <= rx_s;
    end
  end

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic       aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic       w_held_reg;
  logic [7:0] w_data_reg;
  logic       w_lane_reg;
  logic       rd_pend_reg;
  logic [7:0] rd_addr_reg;
  logic       wr_fire;
  logic [7:0] rd_word;

  assign o_awready = !aw_held_reg && !o_bvalid;
  assign o_wready  = !w_held_reg && !o_bvalid;
  assign o_arready = !rd_pend_reg && !o_rvalid;
  assign wr_fire   = aw_held_reg && w_held_reg && !o_bvalid;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_lane_reg  <= 1'b0;
      o_bvalid    <= 1'b0;
      o_bresp     <= pms_pkg::RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= i_wdata[7:0];
        w_lane_reg <= i_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        o_bvalid    <= 1'b1;
        o_bresp     <= is_mapped(aw_addr_reg) ? pms_pkg::RESP_OKAY
                                              : pms_pkg::RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // only the low byte lane carries register bits
  logic wr_ok;
  assign wr_ok = wr_fire && w_lane_reg;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : wr_hit

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      o_rvalid    <= 1'b0;
      o_rdata     <= 32'h0000_0000;
      o_rresp     <= pms_pkg::RESP_OKAY;
    end else begin
      if (i_arvalid && o_arready) begin
        rd_pend_reg <= 1'b1;
        rd_addr_reg <= i_araddr;
      end
      if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        o_rvalid    <= 1'b1;
        o_rdata     <= {24'h00_0000, rd_word};
        o_rresp     <= is_mapped(rd_addr_reg) ? pms_pkg::RESP_OKAY
                                              : pms_pkg::RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // retained user bytes
  // ****************************************************************
  logic [7:0] retain_rd;

  pms_retain_mem #(
    .WORDS (pms_pkg::RETAIN_WORDS),
    .WIDTH (8)
  ) u_retain (
    .i_clock   (i_clock),
    .i_wr_en   (wr_ok && is_retain(aw_addr_reg)), // [RULE8]
    .i_wr_addr (retain_index(aw_addr_reg)),
    .i_wr_data (w_data_reg),
    .i_rd_addr (retain_index(i_araddr)),
    .o_rd_data (retain_rd)
  );

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [1:0] rx_cfg_reg;
  logic       rx_flag_reg;
  logic       edge_sel_reg;
  logic       pend_reg;
  logic [2:0] irq_one_cfg_reg;
  logic [4:0] switch_reg;
  logic       display_reg;
  logic       sleep_cmd;
  logic       swreset_cmd;
  logic       irq_one_edge;
  logic       rx_edge;
  pms_pkg::pms_mode_t mode_reg;

  assign sleep_cmd   = wr_ok && wr_hit(aw_addr_reg, pms_pkg::REG_POWER_CONTROL)
                       && w_data_reg[pms_pkg::PWR_SLEEP_BIT];
  assign swreset_cmd = wr_ok && wr_hit(aw_addr_reg, pms_pkg::REG_POWER_CONTROL)
                       && w_data_reg[pms_pkg::PWR_SWRESET_BIT];

  // edge select high: falling edge; low: rising edge
  assign irq_one_edge = edge_sel_reg ? (irq_one_prev_reg && !irq_one_s)
                                     : (!irq_one_prev_reg && irq_one_s);
  assign rx_edge      = rx_prev_reg != rx_s;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rx_cfg_reg      <= 2'h0;
      irq_one_cfg_reg <= 3'h0;
      edge_sel_reg    <= 1'b0;
      switch_reg      <= pms_pkg::SWITCH_RESET;
      display_reg     <= 1'b0;
    end else if (wr_ok) begin
      unique case (aw_addr_reg)
        pms_pkg::REG_PERIPHERAL_CONFIG_REG_CONFIG:  rx_cfg_reg      <= w_data_reg[1:0];
        pms_pkg::REG_IRQ_ONE_CONFIG: irq_one_cfg_reg <= w_data_reg[2:0];
        pms_pkg::REG_TIMER_CONTROL:
          edge_sel_reg <= w_data_reg[pms_pkg::TIMER_CONTROL_REG_EDGE_BIT];
        pms_pkg::REG_SWITCH_CONTROL: switch_reg      <= w_data_reg[4:0];
        // writable in every mode, sleep included
        pms_pkg::REG_DISPLAY:
          display_reg <= w_data_reg[pms_pkg::DISP_ON_BIT]; // [RULE7]
        default: ;
      endcase
    end
  end

  // flags: a hardware set in the clearing cycle wins
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rx_flag_reg <= 1'b0;
    end else if (rx_cfg_reg == pms_pkg::RX_WAKE_CFG && rx_edge) begin
      rx_flag_reg <= 1'b1; // [RULE4]
    end else if (wr_ok && wr_hit(aw_addr_reg, pms_pkg::REG_PERIPHERAL_CONFIG_REG_CONFIG)
                 && !w_data_reg[pms_pkg::PER_RX_FLAG_BIT]) begin
      rx_flag_reg <= 1'b0;
    end
  end

  // pending flag only follows edges while the core runs, so a wake
  // edge during sleep leaves it as software left it
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pend_reg <= 1'b0;
    end else if (irq_one_edge && mode_reg != pms_pkg::PMS_SLEEP) begin
      pend_reg <= 1'b1; // [RULE2]
    end else if (wr_ok && wr_hit(aw_addr_reg, pms_pkg::REG_TIMER_CONTROL)
                 && !w_data_reg[pms_pkg::TIMER_CONTROL_REG_PEND_BIT]) begin
      pend_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // supply source selection
  // ****************************************************************
  logic [$clog2(DC_DELAY_CYCLES+1)-1:0] dc_cnt_reg;
  logic on_battery_reg;
  logic dc_armed;
  logic dc_done;
  logic go_battery;
  logic go_main;

  assign dc_armed = switch_reg[pms_pkg::SW_AUTO_DC] && dc_low;
  assign dc_done  = dc_armed &&
    dc_cnt_reg == ($clog2(DC_DELAY_CYCLES+1))'(DC_DELAY_CYCLES);
  assign go_battery = !main_ok || dc_done ||
                      (switch_reg[pms_pkg::SW_AUTO_MAIN] && main_low);
  assign go_main    = main_ok && !main_low && !dc_armed;

  // delay restarts whenever the enable or the low dc condition drops
  always_ff @(posedge i_clock) begin
    if (i_reset || !dc_armed || on_battery_reg) begin
      dc_cnt_reg <= '0;
    end else if (!dc_done) begin
      dc_cnt_reg <= dc_cnt_reg + 1'b1; // [RULE21]
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      on_battery_reg <= 1'b0;
    end else if (!on_battery_reg && go_battery) begin
      on_battery_reg <= 1'b1;
    end else if (on_battery_reg && go_main) begin
      on_battery_reg <= 1'b0; // [RULE22]
    end
  end

  // ****************************************************************
  // operating mode
  // ****************************************************************
  logic wake;
  logic restart_reg;

  assign wake = !reset_pin_n_s // [RULE6]
             || (irq_one_cfg_reg[2:1] == pms_pkg::IRQ1_WAKE_CFG
                 && irq_one_edge) // [RULE1]
             || (rx_cfg_reg == pms_pkg::RX_WAKE_CFG && rx_edge); // [RULE4]

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mode_reg    <= pms_pkg::PMS_FULL_SUPPLY; // [RULE23]
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= swreset_cmd;
      unique case (mode_reg)
        pms_pkg::PMS_FULL_SUPPLY: begin
          if (on_battery_reg) begin
            mode_reg <= pms_pkg::PMS_BATTERY_RUN; // [RULE9] [RULE10]
          end
        end
        pms_pkg::PMS_BATTERY_RUN: begin
          if (!on_battery_reg) begin
            mode_reg <= pms_pkg::PMS_FULL_SUPPLY; // [RULE14]
          end else if (sleep_cmd) begin
            mode_reg <= pms_pkg::PMS_SLEEP; // [RULE11]
          end
        end
        pms_pkg::PMS_SLEEP: begin
          if (!on_battery_reg) begin
            mode_reg    <= pms_pkg::PMS_FULL_SUPPLY; // [RULE13]
            restart_reg <= 1'b1;
          end else if (wake) begin
            mode_reg    <= pms_pkg::PMS_BATTERY_RUN;
            restart_reg <= 1'b1; // [RULE12]
          end
        end
        default: mode_reg <= pms_pkg::PMS_FULL_SUPPLY;
      endcase
    end
  end

  // ****************************************************************
  // outputs and read mux
  // ****************************************************************
  logic wake_reg;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= mode_reg == pms_pkg::PMS_SLEEP &&
                  (wake || !on_battery_reg);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_power <= '0;
    end else begin
      o_power.supply_on_battery <= on_battery_reg;
      o_power.core_run          <= mode_reg != pms_pkg::PMS_SLEEP;
      o_power.core_restart      <= restart_reg;
      o_power.analog_enable     <=
        mode_reg == pms_pkg::PMS_FULL_SUPPLY; // [RULE10] [RULE13] [RULE14]
      o_power.display_enable    <= display_reg; // [RULE7]
      o_power.early_warning     <= main_low ||
        (switch_reg[pms_pkg::SW_DC_WARN] && dc_low); // [RULE19]
      o_power.wake_event        <= wake_reg;
    end
  end

  assign o_mode = mode_reg;

  always_comb begin
    rd_word = 8'h00;
    if (is_retain(rd_addr_reg)) begin
      rd_word = retain_rd; // [RULE8]
    end else begin
      unique case (rd_addr_reg)
        pms_pkg::REG_POWER_CONTROL:
          rd_word[pms_pkg::PWR_SLEEP_BIT] = mode_reg == pms_pkg::PMS_SLEEP;
        pms_pkg::REG_PERIPHERAL_CONFIG_REG_CONFIG: begin
          rd_word[pms_pkg::PER_RX_FLAG_BIT] = rx_flag_reg;
          rd_word[pms_pkg::PER_SOURCE_BIT]  = !on_battery_reg; // [RULE16]
          rd_word[1:0]                      = rx_cfg_reg;
        end
        pms_pkg::REG_TIMER_CONTROL: begin
          rd_word[pms_pkg::TIMER_CONTROL_REG_PEND_BIT] = pend_reg;
          rd_word[pms_pkg::TIMER_CONTROL_REG_EDGE_BIT] = edge_sel_reg;
        end
        pms_pkg::REG_IRQ_ONE_CONFIG: rd_word[2:0] = irq_one_cfg_reg;
        pms_pkg::REG_SWITCH_CONTROL: rd_word[4:0] = switch_reg;
        pms_pkg::REG_STATUS:
          rd_word[5:0] = {dc_low, main_low, main_ok,
                          on_battery_reg, mode_reg};
        pms_pkg::REG_DISPLAY: rd_word[pms_pkg::DISP_ON_BIT] = display_reg;
        default: rd_word = 8'h00;
      endcase
    end
  end

endmodule : pms_mode_ctrl

//--- verification/pms_mode_ctrl_sva.sv
// assertions on the power mode sequencer ports
`timescale 1ns/1ps
module pms_mode_ctrl_sva (
  input wire logic                 i_clock,
  input wire logic                 i_reset,
  input wire pms_pkg::pms_supply_t i_supply,
  input wire logic                 i_reset_pin_n,
  input wire pms_pkg::pms_mode_t   o_mode,
  input wire pms_pkg::pms_power_t  o_power
);
  wire slp = o_mode == pms_pkg::PMS_SLEEP;
  wire bat = o_mode == pms_pkg::PMS_BATTERY_RUN;
  wire ful = o_mode == pms_pkg::PMS_FULL_SUPPLY;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // ****************
  // modes, transitions and early warning
  // ****************
  property p_sleep_core; slp && $past(slp) |-> !o_power.core_run; endproperty
  a_sleep_core: assert property (p_sleep_core)
    else $error("core on");
  property p_bat_analog; bat && $past(bat) |-> !o_power.analog_enable;
  endproperty
  a_bat_analog: assert property (p_bat_analog)
    else $error("analog");
  property p_wake_bat;
    $past(slp) && bat |=> o_power.core_restart && o_power.wake_event;
  endproperty
  a_wake_bat: assert property (p_wake_bat)
    else $error("no restart");
  property p_wake_full;
    $past(slp) && ful |=> o_power.core_restart && o_power.analog_enable;
  endproperty
  a_wake_full: assert property (p_wake_full)
    else $error("full wake");
  property p_run_full; $past(bat) && ful |=> !o_power.core_restart;
  endproperty
  a_run_full: assert property (p_run_full) else $error("restart");
  property p_legal; 2'(o_mode) != 2'h3; endproperty
  a_legal: assert property (p_legal) else $error("bad mode");
  property p_pin_wake; slp && !i_reset_pin_n |-> ##[1:6] !slp; endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake");
  property p_main_lost; (!i_supply.main_ok) [*6] |-> !ful; endproperty
  a_main_lost: assert property (p_main_lost) else $error("mode");
  property p_warn; i_supply.main_low [*6] |-> o_power.early_warning;
  endproperty
  a_warn: assert property (p_warn) else $error("no warning");
endmodule : pms_mode_ctrl_sva
bind pms_mode_ctrl pms_mode_ctrl_sva pms_mode_ctrl_sva_inst (
  .i_clock(i_clock), .i_reset(i_reset), .i_supply(i_supply),
  .i_reset_pin_n(i_reset_pin_n), .o_mode(o_mode), .o_power(o_power));

//--- verification/tb_top.sv
// self-checking bench of the power mode sequencer
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;
  } pms_row_t;
  logic i_clock, i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic i_irq_one_pin, i_rx_pin, i_reset_pin_n;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [3:0]  i_wstrb;
  logic [1:0]  o_bresp, o_rresp, rs;
  pms_pkg::pms_supply_t i_supply;
  pms_pkg::pms_mode_t   o_mode;
  pms_pkg::pms_power_t  o_power;
  int num_errors, check_count, restarts;
  pms_row_t rows [10] = '{
    '{8'h18, 32'h01, 32'h01, 2'h0}, '{8'h0C, 32'h06, 32'h06, 2'h0},
    '{8'h08, 32'h04, 32'h04, 2'h0}, '{8'h10, 32'h1F, 32'h1F, 2'h0},
    '{8'h10, 32'h04, 32'h04, 2'h0}, '{8'h04, 32'h03, 32'h43, 2'h0},
    '{8'h20, 32'hA5, 32'hA5, 2'h0}, '{8'h24, 32'h5A, 32'h5A, 2'h0},
    '{8'h2C, 32'h3C, 32'h3C, 2'h0}, '{8'h40, 32'h12, 32'h00, 2'h2}};
  pms_mode_ctrl #(.DC_DELAY_CYCLES(20)) pms_mode_ctrl_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .i_supply(i_supply), .i_irq_one_pin(i_irq_one_pin),
    .i_rx_pin(i_rx_pin), .i_reset_pin_n(i_reset_pin_n), .o_mode(o_mode),
    .o_power(o_power));
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (o_power.core_restart === 1'b1) restarts++;
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    int n;
    ad = 0; wd = 0; n = 0;
    @(posedge i_clock);
    i_awvalid <= 1; i_awaddr <= a; i_wvalid <= 1; i_wdata <= d; i_bready <= 1;
    while (n < 100) begin
      @(posedge i_clock);
      n++;
      if (!ad && o_awready) begin ad = 1; i_awvalid <= 0; end
      if (!wd && o_wready) begin wd = 1; i_wvalid <= 0; end
      if (o_bvalid === 1'b1) begin rs = o_bresp; i_bready <= 0; break; end
    end
    chk("write_wait", 0, 32'(n == 100));
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    bit ad;
    int n;
    ad = 0; n = 0;
    @(posedge i_clock);
    i_arvalid <= 1; i_araddr <= a; i_rready <= 1;
    while (n < 100) begin
      @(posedge i_clock);
      n++;
      if (!ad && o_arready) begin ad = 1; i_arvalid <= 0; end
      if (o_rvalid === 1'b1) begin
        rd = o_rdata; rs = o_rresp; i_rready <= 0; break;
      end
    end
    chk("read_wait", 0, 32'(n == 100));
  endtask : axi_rd
  task automatic wait_mode(input pms_pkg::pms_mode_t m, input int lim);
    int n;
    n = 0;
    while (o_mode !== m && n < lim) begin @(posedge i_clock); n++; end
    chk("mode", 32'(m), 32'(o_mode));
  endtask : wait_mode
  task automatic go_sleep;
    axi_wr(8'h00, 32'h10);
    wait_mode(pms_pkg::PMS_SLEEP, 10);
  endtask : go_sleep
  task give_verdict;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // ***************************
  // watchdog, ~50000 clock cycles
  // ***************************
  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
  initial begin
    i_reset = 1; i_awvalid = 0; i_wvalid = 0; i_bready = 0; i_arvalid = 0;
    i_rready = 0; i_awaddr = 0; i_araddr = 0; i_wdata = 0; i_wstrb = 4'hF;
    i_supply = '{1'b1, 1'b0, 1'b0}; i_irq_one_pin = 0; i_rx_pin = 1;
    i_reset_pin_n = 1; restarts = 0; num_errors = 0; check_count = 0;
    repeat (16) @(posedge i_clock);
    i_reset <= 0;
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].d);
      chk("wresp", 32'(rows[i].r), 32'(rs));
      axi_rd(rows[i].a);
      chk("rdata", rows[i].q, rd);
      chk("rresp", 32'(rows[i].r), 32'(rs));
    end
    // main supply lost while running
    i_supply.main_ok <= 0;
    wait_mode(pms_pkg::PMS_BATTERY_RUN, 20);
    repeat (3) @(posedge i_clock);
    chk("analog", 0, 32'(o_power.analog_enable));
    chk("on_bat", 1, 32'(o_power.supply_on_battery));
    axi_wr(8'h10, 32'h06);
    axi_rd(8'h04);
    chk("peripheral_config_reg", 32'h03, rd);
    i_irq_one_pin <= 1;
    axi_wr(8'h08, 32'h04);
    go_sleep();
    axi_wr(8'h18, 32'h00);
    axi_rd(8'h18);
    chk("display", 32'h00, rd);
    chk("disp_en", 0, 32'(o_power.display_enable));
    i_reset_pin_n <= 0;
    wait_mode(pms_pkg::PMS_BATTERY_RUN, 20);
    i_reset_pin_n <= 1;
    repeat (4) @(posedge i_clock);
    chk("restarts", 1, restarts);
    // falling edge selected: wake must not set the pending flag
    go_sleep();
    i_irq_one_pin <= 0;
    wait_mode(pms_pkg::PMS_BATTERY_RUN, 20);
    axi_rd(8'h08);
    chk("timer", 32'h04, rd);
    go_sleep();
    i_rx_pin <= 0;
    wait_mode(pms_pkg::PMS_BATTERY_RUN, 20);
    axi_rd(8'h04);
    chk("rx_flag", 32'h83, rd);
    axi_wr(8'h04, 32'h03);
    go_sleep();
    i_supply.main_ok <= 1;
    wait_mode(pms_pkg::PMS_FULL_SUPPLY, 20);
    axi_rd(8'h04);
    chk("source", 32'h43, rd);
    axi_rd(8'h2C);
    chk("retain", 32'h3C, rd);
    chk("restarts", 4, restarts);
    // battery run back to full: code continues
    i_supply.main_ok <= 0;
    wait_mode(pms_pkg::PMS_BATTERY_RUN, 20);
    i_supply.main_ok <= 1;
    wait_mode(pms_pkg::PMS_FULL_SUPPLY, 20);
    repeat (4) @(posedge i_clock);
    chk("restarts", 4, restarts);
    chk("analog", 1, 32'(o_power.analog_enable));
    axi_wr(8'h00, 32'h80);
    repeat (2) @(posedge i_clock);
    chk("restarts", 5, restarts);
    axi_wr(8'h10, 32'h01);
    i_supply.main_low <= 1;
    repeat (8) @(posedge i_clock);
    chk("warning", 1, 32'(o_power.early_warning));
    i_supply.main_low <= 0;
    // low dc switchover after the delay count of 20
    axi_wr(8'h10, 32'h0C);
    i_supply.dc_low <= 1;
    repeat (20) @(posedge i_clock);
    chk("mode", 32'(pms_pkg::PMS_FULL_SUPPLY), 32'(o_mode));
    wait_mode(pms_pkg::PMS_BATTERY_RUN, 8);
    i_reset <= 1;
    repeat (3) @(posedge i_clock);
    i_reset <= 0;
    repeat (3) @(posedge i_clock);
    chk("mode", 32'(pms_pkg::PMS_FULL_SUPPLY), 32'(o_mode));
    i_supply.dc_low <= 0;
    give_verdict();
  end
endmodule : tb_top
